// [rtl/scp_top.v]
// Behaviour
// RQ1 - select_n low gates serial cycles; high ignores the clock
// RQ2 - frame starts at first rising serial clock after select falls
// RQ3 - select held low keeps streaming bytes with address stepping
// RQ4 - select high between bytes stalls; frame state is held
// RQ5 - select idle high releases data pin and enables secondary functions
// RQ6 - frame opens with a 16-bit instruction
// RQ7 - data phase length taken from the two length bits
// RQ8 - data moves as 8-bit words
// RQ9 - first instruction bit is the read flag
// RQ10 - on read the device drives the data pin during data phase
// RQ11 - msb first after reset; config bit selects lsb first
// RQ12 - host should keep port idle during critical sampling
// RQ13 - requantizer settings held per channel
// RQ14 - mode 000 selects narrow band, 0.22 wide
// RQ15 - mode 001 selects wide band, 0.33 wide
// RQ16 - band position from 6-bit tuning word
// RQ17 - narrow band tuning words 0 to 56 valid
// RQ18 - wide band tuning words 0 to 33 valid
// RQ19 - left edge moves 0.005 of sample rate per tuning step
// RQ20 - requantizer on scales output by -0.6 dB
// RQ21 - sync control chooses one-shot or every-pulse divider resync
// RQ22 - external sync passes a synchroniser first
// RQ23 - shadowed writes apply on transfer write; transfer bit self-clears
// RQ24 - channel index selects channels; both write both, read returns A
// RQ25 - requantizer on raises latency from 10 to 13 cycles
// RQ26 - instruction: read flag, two length bits, 13-bit address
// RQ27 - length codes one to three bytes; fourth streams
`timescale 1ns/10ps
`default_nettype none
`include "scp_map.vh"
module scp_top (
  input  wire        clk_in,
  input  wire        arst_n_in,
  input  wire        sclk_in,
  input  wire        select_n_in,
  input  wire        sdio_in,
  input  wire        sync_pin_in,
  output reg         sdio_out,
  output reg         sdio_oe_out,
  output reg         secondary_en_out,
  output reg  [1:0]  req_enable_out,
  output reg  [5:0]  req_mode_out,
  output reg  [11:0] band_tuning_word_out,
  output reg  [5:0]  tune_valid_out,
  output reg  [21:0] out_gain_out,
  output reg  [7:0]  pipe_latency_out,
  output reg         divider_resync_out
);
  localparam ST_INSTR = 2'h0;
  localparam ST_DATA  = 2'h1;
  localparam ST_DONE  = 2'h2;

  // tuning word range check for the selected band; both bounds inclusive
  function valid_tune;
    input [2:0] mode;
    input [5:0] tw;
    begin
      if (mode == `SCP_MODE_NARROW)
        valid_tune = (tw <= `SCP_TUNE_MAX_NARROW);
      else if (mode == `SCP_MODE_WIDE)
        valid_tune = (tw <= `SCP_TUNE_MAX_WIDE);
      else
        valid_tune = 1'b0;
    end
  endfunction

  function [7:0] bit_rev;
    input [7:0] v;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1)
        bit_rev[i] = v[7 - i];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  wire sclk_s;
  wire sel_act_s;
  wire sdio_s;
  wire sync_s;
  scp_sync u_sync_sclk (.clk_in(clk_in), .arst_n_in(arst_n_in), .async_in(sclk_in),
    .sync_out(sclk_s));
  // select is inverted ahead of its synchroniser so reset matches the idle level
  scp_sync u_sync_sel (.clk_in(clk_in), .arst_n_in(arst_n_in), .async_in(~select_n_in),
    .sync_out(sel_act_s));
  scp_sync u_sync_sdio (.clk_in(clk_in), .arst_n_in(arst_n_in), .async_in(sdio_in),
    .sync_out(sdio_s));
  scp_sync u_sync_ext (.clk_in(clk_in), .arst_n_in(arst_n_in), .async_in(sync_pin_in),
    .sync_out(sync_s)); // RQ22
  wire sel_n_s = ~sel_act_s;

  reg sclk_q;
  reg sel_n_q;
  reg sync_q;
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sclk_q  <= 1'b0;
      sel_n_q <= 1'b1;
      sync_q  <= 1'b0;
    end else begin
      sclk_q  <= sclk_s;
      sel_n_q <= sel_n_s;
      sync_q  <= sync_s;
    end
  end
  wire sclk_rise = sclk_s & ~sclk_q & ~sel_n_s; // RQ1
  wire sclk_fall = ~sclk_s & sclk_q & ~sel_n_s;
  wire sel_fall  = sel_n_q & ~sel_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg [7:0]  cfg_q;
  reg [7:0]  idx_q;
  reg [7:0]  sync_ctrl_q;
  reg [7:0]  sync_ctrl_live_q;
  reg [15:0] ctrl_sh_q;
  reg [15:0] tune_sh_q;
  reg [15:0] ctrl_live_q;
  reg [15:0] tune_live_q;
  reg        xfer_q;
  reg        synced_once_q;

  ////////////////////////////////////////////////////////////////////////////
  // serial engine
  reg [1:0]  st_q;
  reg [4:0]  cnt_q;
  reg [15:0] instr_q;
  reg [7:0]  shift_q;
  reg [1:0]  bytes_q;
  reg [12:0] addr_q;

  wire        lsb_first = cfg_q[`SCP_CFG_LSB_FIRST_BIT]; // RQ11
  wire        is_read   = instr_q[15];                   // RQ9
  wire [15:0] instr_nx  = {instr_q[14:0], sdio_s};
  wire [7:0]  byte_nx   = {shift_q[6:0], sdio_s};
  wire [7:0]  wr_byte   = lsb_first ? bit_rev(byte_nx) : byte_nx; // RQ11

  // read mux; unmapped addresses return zero
  reg [7:0] rd_val;
  always @* begin
    rd_val = 8'h00;
    case (addr_q)
      `SCP_ADDR_PORT_CFG:   rd_val = cfg_q;
      `SCP_ADDR_CHAN_INDEX: rd_val = idx_q;
      `SCP_ADDR_SYNC_CTRL:  rd_val = sync_ctrl_q;
      `SCP_ADDR_REQ_CTRL:   rd_val = idx_q[`SCP_IDX_CHAN_A_BIT] ? ctrl_sh_q[7:0]
                                     : ctrl_sh_q[15:8]; // RQ24
      `SCP_ADDR_REQ_TUNE:   rd_val = idx_q[`SCP_IDX_CHAN_A_BIT] ? tune_sh_q[7:0]
                                     : tune_sh_q[15:8]; // RQ24
      `SCP_ADDR_TRANSFER:   rd_val = {7'h00, xfer_q};
      default:              rd_val = 8'h00;
    endcase
  end
  wire [7:0] rd_ord = lsb_first ? bit_rev(rd_val) : rd_val;

  wire data_done = sclk_rise && (st_q == ST_DATA) && (cnt_q == 5'h07);
  wire do_write  = data_done && !is_read;

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q     <= ST_INSTR;
      cnt_q    <= 5'h00;
      instr_q  <= 16'h0000;
      shift_q  <= 8'h00;
      bytes_q  <= 2'h0;
      addr_q   <= 13'h0000;
      sdio_out    <= 1'b0;
      sdio_oe_out <= 1'b0;
    end else begin
      if (sel_fall && st_q == ST_DONE) begin // RQ2
        st_q  <= ST_INSTR;
        cnt_q <= 5'h00;
      end else if (sclk_rise) begin
        // select high between bytes only pauses the counters; RQ4
        case (st_q)
          ST_INSTR: begin
            instr_q <= instr_nx;
            if (cnt_q == `SCP_INSTR_BITS - 5'h01) begin // RQ6
              st_q    <= ST_DATA;
              cnt_q   <= 5'h00;
              addr_q  <= instr_nx[12:0];   // RQ26
              bytes_q <= instr_nx[14:13];  // RQ7 RQ27
            end else begin
              cnt_q <= cnt_q + 5'h01;
            end
          end
          ST_DATA: begin
            shift_q <= byte_nx;
            if (cnt_q == 5'h07) begin // RQ8
              cnt_q  <= 5'h00;
              addr_q <= addr_q - 13'h0001;
              if (bytes_q == 2'h3)
                st_q <= ST_DATA; // RQ3
              else if (bytes_q == 2'h0)
                st_q <= ST_DONE;
              else
                bytes_q <= bytes_q - 2'h1;
            end else begin
              cnt_q <= cnt_q + 5'h01;
            end
          end
          default: st_q <= st_q;
        endcase
      end
      // read data launched on falling edges, host samples on rising
      if (sel_n_s) begin
        sdio_oe_out <= 1'b0; // RQ5
      end else if (st_q == ST_DATA && is_read && !sclk_rise) begin
        sdio_oe_out <= 1'b1; // RQ10
        // a turned-round or resumed pin loads the pending bit at once
        if (sclk_fall || !sdio_oe_out)
          sdio_out <= rd_ord[3'h7 - cnt_q[2:0]];
      end else if (st_q != ST_DATA) begin
        sdio_oe_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes, shadow and transfer
  wire wr_a = idx_q[`SCP_IDX_CHAN_A_BIT];
  wire wr_b = idx_q[`SCP_IDX_CHAN_B_BIT];
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_q       <= `SCP_RST_PORT_CFG;
      idx_q       <= `SCP_RST_CHAN_INDEX;
      sync_ctrl_q <= `SCP_RST_SYNC_CTRL;
      sync_ctrl_live_q <= `SCP_RST_SYNC_CTRL;
      ctrl_sh_q   <= {2{`SCP_RST_REQ_CTRL}};
      tune_sh_q   <= {2{`SCP_RST_REQ_TUNE}};
      ctrl_live_q <= {2{`SCP_RST_REQ_CTRL}};
      tune_live_q <= {2{`SCP_RST_REQ_TUNE}};
      xfer_q      <= 1'b0;
    end else begin
      if (xfer_q) begin
        ctrl_live_q      <= ctrl_sh_q; // RQ23
        tune_live_q      <= tune_sh_q;
        sync_ctrl_live_q <= sync_ctrl_q;
        xfer_q           <= 1'b0;      // RQ23
      end
      if (do_write) begin
        case (addr_q)
          `SCP_ADDR_PORT_CFG:   cfg_q <= wr_byte;
          `SCP_ADDR_CHAN_INDEX: idx_q <= wr_byte;
          `SCP_ADDR_SYNC_CTRL:  sync_ctrl_q <= wr_byte;
          `SCP_ADDR_REQ_CTRL: begin
            if (wr_a) ctrl_sh_q[7:0]  <= wr_byte; // RQ13 RQ24
            if (wr_b) ctrl_sh_q[15:8] <= wr_byte;
          end
          `SCP_ADDR_REQ_TUNE: begin
            if (wr_a) tune_sh_q[7:0]  <= wr_byte; // RQ24
            if (wr_b) tune_sh_q[15:8] <= wr_byte;
          end
          `SCP_ADDR_TRANSFER: xfer_q <= wr_byte[`SCP_XFER_BIT];
          default: xfer_q <= xfer_q;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // requantizer settings per channel; secondary enable and the single sync output
  integer c;
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      req_enable_out       <= 2'h0;
      req_mode_out         <= 6'h00;
      band_tuning_word_out <= 12'h000;
      tune_valid_out       <= 6'h00;
      out_gain_out         <= {2{`SCP_GAIN_UNITY}};
      pipe_latency_out     <= {2{`SCP_LAT_PLAIN}};
      secondary_en_out     <= 1'b1;
      divider_resync_out   <= 1'b0;
      synced_once_q        <= 1'b0;
    end else begin
      for (c = 0; c < 2; c = c + 1) begin
        req_enable_out[c] <= ctrl_live_q[c*8 + `SCP_REQ_EN_BIT]; // RQ13
        req_mode_out[c*3 +: 3] <= ctrl_live_q[c*8 + `SCP_REQ_MODE_LO +: 3]; // RQ14 RQ15
        band_tuning_word_out[c*6 +: 6] <= tune_live_q[c*8 +: 6]; // RQ16 RQ19
        tune_valid_out[c*3 +: 3] <= {2'h0,
          valid_tune(ctrl_live_q[c*8 + `SCP_REQ_MODE_LO +: 3],
                     tune_live_q[c*8 +: 6])}; // RQ17 RQ18
        out_gain_out[c*11 +: 11] <= ctrl_live_q[c*8 + `SCP_REQ_EN_BIT] ? `SCP_GAIN_REQUANT
                                    : `SCP_GAIN_UNITY; // RQ20
        pipe_latency_out[c*4 +: 4] <= ctrl_live_q[c*8 + `SCP_REQ_EN_BIT] ? `SCP_LAT_REQUANT
                                      : `SCP_LAT_PLAIN; // RQ25
      end
      secondary_en_out <= sel_n_s && (st_q != ST_DATA) && (cnt_q == 5'h00); // RQ5
      divider_resync_out <= 1'b0;
      if (sync_s && !sync_q && sync_ctrl_live_q[`SCP_SYNC_EN_BIT]) begin
        if (!sync_ctrl_live_q[`SCP_SYNC_ONCE_BIT] || !synced_once_q) begin // RQ21
          divider_resync_out <= 1'b1;
          synced_once_q      <= 1'b1;
        end
      end
      if (!sync_ctrl_live_q[`SCP_SYNC_EN_BIT])
        synced_once_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [rtl/scp_map.vh]
`ifndef SCP_MAP_VH
`define SCP_MAP_VH
// register offsets
`define SCP_ADDR_PORT_CFG   13'h0000
`define SCP_ADDR_CHAN_INDEX 13'h0005
`define SCP_ADDR_SYNC_CTRL  13'h003A
`define SCP_ADDR_REQ_CTRL   13'h003C
`define SCP_ADDR_REQ_TUNE   13'h003E
`define SCP_ADDR_TRANSFER   13'h00FF
// field positions
`define SCP_CFG_LSB_FIRST_BIT 6
`define SCP_IDX_CHAN_A_BIT    0
`define SCP_IDX_CHAN_B_BIT    1
`define SCP_XFER_BIT          0
`define SCP_REQ_EN_BIT        0
`define SCP_REQ_MODE_LO       1
`define SCP_REQ_MODE_HI       3
`define SCP_TUNE_HI           5
`define SCP_SYNC_EN_BIT       1
`define SCP_SYNC_ONCE_BIT     2
// field values and reset values
`define SCP_MODE_NARROW     3'h0
`define SCP_MODE_WIDE       3'h1
`define SCP_TUNE_MAX_NARROW 6'h38
`define SCP_TUNE_MAX_WIDE   6'h21
`define SCP_RST_PORT_CFG    8'h00
`define SCP_RST_CHAN_INDEX  8'h03
`define SCP_RST_SYNC_CTRL   8'h00
`define SCP_RST_REQ_CTRL    8'h00
`define SCP_RST_REQ_TUNE    8'h00
// timing counts in sample clocks
`define SCP_LAT_PLAIN       4'hA
`define SCP_LAT_REQUANT     4'hD
// output gain in 1/1024: 10^(-0.6/20) = 0.9333
`define SCP_GAIN_REQUANT    11'h3BB
`define SCP_GAIN_UNITY      11'h400
`define SCP_INSTR_BITS      5'h10
`endif

// [rtl/scp_sync.v]
`timescale 1ns/10ps
`default_nettype none
module scp_sync (
  input  wire clk_in,
  input  wire arst_n_in,
  input  wire async_in,
  output wire sync_out
);
  reg meta_q;
  reg stab_q;
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= 1'b0;
      stab_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      stab_q <= meta_q;
    end
  end
  assign sync_out = stab_q;
endmodule
`default_nettype wire

// [tb/scp_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module scp_chk (
  input wire logic        clk_in,
  input wire logic        arst_n_in,
  input wire logic        sclk_in,
  input wire logic        select_n_in,
  input wire logic        sdio_in,
  input wire logic        sync_pin_in,
  input wire logic        sdio_out,
  input wire logic        sdio_oe_out,
  input wire logic        secondary_en_out,
  input wire logic [1:0]  req_enable_out,
  input wire logic [5:0]  req_mode_out,
  input wire logic [11:0] band_tuning_word_out,
  input wire logic [5:0]  tune_valid_out,
  input wire logic [21:0] out_gain_out,
  input wire logic [7:0]  pipe_latency_out,
  input wire logic        divider_resync_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  a_oe_idle: assert property (select_n_in [*5] |-> !sdio_oe_out)
    else $error("data pin driven while deselected");
  a_sec_frame: assert property ($fell(select_n_in) |-> ##[1:5] !secondary_en_out)
    else $error("secondary functions kept during frame");
  a_sec_oe: assert property (!(sdio_oe_out && secondary_en_out))
    else $error("pin driven with secondary functions on");
  a_bit_edge: assert property (sdio_oe_out && $past(sdio_oe_out) && $changed(sdio_out) |-> !sclk_in)
    else $error("read bit changed while serial clock high");
  a_lat_a: assert property ($stable(req_enable_out) |->
    pipe_latency_out[3:0] == (req_enable_out[0] ? 4'hD : 4'hA))
    else $error("channel a latency wrong");
  a_gain_b: assert property ($stable(req_enable_out) |->
    out_gain_out[21:11] == (req_enable_out[1] ? 11'h3BB : 11'h400))
    else $error("channel b gain wrong");
  a_tune_a: assert property ($stable(req_mode_out) && $stable(band_tuning_word_out) && tune_valid_out[0]
    |-> (req_mode_out[2:0] == 3'h0 && band_tuning_word_out[5:0] < 6'h39)
    || (req_mode_out[2:0] == 3'h1 && band_tuning_word_out[5:0] < 6'h22))
    else $error("tuning word flagged valid out of range");
  a_resync_one: assert property (divider_resync_out |=> !divider_resync_out)
    else $error("resync pulse longer than one cycle");
  a_resync_src: assert property (!sync_pin_in [*8] |-> !divider_resync_out)
    else $error("resync without sync input");
endmodule
`default_nettype wire

// [tb/scp_host.sv]
`timescale 1ns/10ps
`default_nettype none
module scp_host (
  input  wire logic clk_in,
  input  wire logic sdio_dev_in,
  input  wire logic sdio_oe_in,
  output logic      sclk_out,
  output logic      select_n_out,
  output logic      sdio_line_out
);
  logic drv_q;
  logic drv_en_q;
  // a released line shows the inverse of the last bit, not a held copy
  assign sdio_line_out = sdio_oe_in ? sdio_dev_in : (drv_en_q ? drv_q : !drv_q);
  initial begin
    sclk_out = 1'b0;
    select_n_out = 1'b1;
    drv_q = 1'b0;
    drv_en_q = 1'b0;
  end
  task half;
    repeat (8) @(posedge clk_in);
    #1;
  endtask
  task bit_cyc(input logic b, output logic s);
    drv_q = b;
    half;
    sclk_out = 1'b1;
    s = sdio_line_out;
    half;
    sclk_out = 1'b0;
  endtask
  task xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wd,
            input logic stall, output logic [7:0] rdat);
    logic [15:0] ins;
    logic        dummy;
    integer      i;
    ins = {rd, 2'b00, addr};
    select_n_out = 1'b0;
    drv_en_q = 1'b1;
    for (i = 15; i >= 0; i--) bit_cyc(ins[i], dummy);
    drv_en_q = !rd;
    if (stall) begin
      select_n_out = 1'b1;
      half;
      half;
      select_n_out = 1'b0;
      half;
    end
    for (i = 7; i >= 0; i--) bit_cyc(wd[i], rdat[i]);
    half;
    select_n_out = 1'b1;
    drv_en_q = 1'b0;
    half;
    half;
  endtask
  // multi-byte write; the first byte sent is wd[23:16]
  task burst(input logic [1:0] len, input logic [12:0] addr, input logic [23:0] wd);
    logic [15:0] ins;
    logic        dummy;
    integer      i;
    integer      nb;
    ins = {1'b0, len, addr};
    nb = len;
    select_n_out = 1'b0;
    drv_en_q = 1'b1;
    for (i = 15; i >= 0; i--) bit_cyc(ins[i], dummy);
    for (i = 0; i < 8 * nb + 8; i++) bit_cyc(wd[23 - i], dummy);
    half;
    select_n_out = 1'b1;
    drv_en_q = 1'b0;
    half;
    half;
  endtask
endmodule
`default_nettype wire

// [tb/tb_scp_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_scp_top;
  logic        clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        sync_pin_in = 1'b0;
  logic        sclk, select_n, sdio_line, sdio_out, sdio_oe_out, secondary_en_out;
  logic [1:0]  req_enable_out;
  logic [5:0]  req_mode_out, tune_valid_out;
  logic [11:0] band_tuning_word_out;
  logic [21:0] out_gain_out;
  logic [7:0]  pipe_latency_out, rq;
  logic        divider_resync_out;
  integer      errors = 0, total_checks = 0, pulses = 0;
  scp_top u_scp_top (.clk_in(clk_in), .arst_n_in(arst_n_in), .sclk_in(sclk),
    .select_n_in(select_n), .sdio_in(sdio_line), .sync_pin_in(sync_pin_in),
    .sdio_out(sdio_out), .sdio_oe_out(sdio_oe_out), .secondary_en_out(secondary_en_out),
    .req_enable_out(req_enable_out), .req_mode_out(req_mode_out),
    .band_tuning_word_out(band_tuning_word_out), .tune_valid_out(tune_valid_out),
    .out_gain_out(out_gain_out), .pipe_latency_out(pipe_latency_out),
    .divider_resync_out(divider_resync_out));
  scp_host u_scp_host (.clk_in(clk_in), .sdio_dev_in(sdio_out), .sdio_oe_in(sdio_oe_out),
    .sclk_out(sclk), .select_n_out(select_n), .sdio_line_out(sdio_line));
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) if (divider_resync_out === 1'b1) pulses <= pulses + 1;
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task wr(input logic [12:0] a, input logic [7:0] d, input logic st);
    u_scp_host.xfer(1'b0, a, d, st, rq);
  endtask
  task rd(input logic [12:0] a);
    u_scp_host.xfer(1'b1, a, 8'h00, 1'b0, rq);
  endtask
  task sync_pulse;
    sync_pin_in = 1'b1;
    repeat (10) @(posedge clk_in);
    #1 sync_pin_in = 1'b0;
    repeat (20) @(posedge clk_in);
    #1;
  endtask
  task t_reset;
    check("oe", sdio_oe_out, 1'b0);
    check("secondary", secondary_en_out, 1'b1);
    check("latency", pipe_latency_out, 8'hAA);
    check("gain", out_gain_out, {11'h400, 11'h400});
  endtask
  task t_both;
    wr(13'h03C, 8'h03, 1'b0);
    wr(13'h03E, 8'h21, 1'b1);
    check("enable early", req_enable_out, 2'h0);
    wr(13'h0FF, 8'h01, 1'b0);
    check("enable", req_enable_out, 2'h3);
    check("mode", req_mode_out, 6'h09);
    check("tune", band_tuning_word_out, 12'h861);
    check("valid", tune_valid_out, 6'h09);
    check("gain", out_gain_out, {11'h3BB, 11'h3BB});
    check("latency", pipe_latency_out, 8'hDD);
    rd(13'h0FF);
    check("transfer bit", rq, 8'h00);
    rd(13'h03C);
    check("ctrl read", rq, 8'h03);
  endtask
  task t_chan_b;
    wr(13'h005, 8'h02, 1'b0);
    wr(13'h03C, 8'h00, 1'b0);
    wr(13'h03E, 8'h38, 1'b0);
    wr(13'h0FF, 8'h01, 1'b0);
    check("enable", req_enable_out, 2'h1);
    check("mode", req_mode_out, 6'h01);
    check("tune", band_tuning_word_out, 12'hE21);
    check("valid", tune_valid_out, 6'h09);
    check("gain", out_gain_out, {11'h400, 11'h3BB});
    check("latency", pipe_latency_out, 8'hAD);
    wr(13'h005, 8'h03, 1'b0);
    rd(13'h03E);
    check("both read a", rq, 8'h21);
    rd(13'h010);
    check("unmapped", rq, 8'h00);
  endtask
  task t_lsb;
    wr(13'h000, 8'h40, 1'b0);
    wr(13'h03E, 8'hA0, 1'b0);
    rd(13'h03E);
    check("lsb read", rq, 8'hA0);
    rd(13'h000);
    check("cfg read", rq, 8'h02);
    wr(13'h000, 8'h00, 1'b0);
  endtask
  task t_burst;
    u_scp_host.burst(2'h2, 13'h03E, {8'h2A, 8'h77, 8'h05});
    rd(13'h03E);
    check("burst first", rq, 8'h2A);
    rd(13'h03D);
    check("burst gap", rq, 8'h00);
    rd(13'h03C);
    check("burst third", rq, 8'h05);
    wr(13'h0FF, 8'h01, 1'b0);
    check("mode other", req_mode_out, 6'h12);
    check("tune both", band_tuning_word_out, 12'hAAA);
    check("valid other", tune_valid_out, 6'h00);
  endtask
  task t_sync;
    wr(13'h03A, 8'h02, 1'b0);
    wr(13'h0FF, 8'h01, 1'b0);
    pulses = 0;
    sync_pulse;
    sync_pulse;
    check("every pulse", pulses, 2);
    wr(13'h03A, 8'h00, 1'b0);
    wr(13'h0FF, 8'h01, 1'b0);
    wr(13'h03A, 8'h06, 1'b0);
    wr(13'h0FF, 8'h01, 1'b0);
    pulses = 0;
    repeat (3) sync_pulse;
    check("one shot", pulses, 1);
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    #1 arst_n_in = 1'b1;
    t_reset;
    repeat (3) @(posedge clk_in);
    #1;
    t_both;
    t_chan_b;
    t_lsb;
    t_burst;
    t_sync;
    stop_test;
  end
  initial begin
    #200000;
    errors++;
    stop_test;
  end
endmodule
bind scp_top scp_chk u_scp_chk (.clk_in(clk_in), .arst_n_in(arst_n_in), .sclk_in(sclk_in),
  .select_n_in(select_n_in), .sdio_in(sdio_in), .sync_pin_in(sync_pin_in),
  .sdio_out(sdio_out), .sdio_oe_out(sdio_oe_out), .secondary_en_out(secondary_en_out),
  .req_enable_out(req_enable_out), .req_mode_out(req_mode_out),
  .band_tuning_word_out(band_tuning_word_out), .tune_valid_out(tune_valid_out),
  .out_gain_out(out_gain_out), .pipe_latency_out(pipe_latency_out),
  .divider_resync_out(divider_resync_out));
`default_nettype wire
